// File: hdl/wmc_map.vh
`ifndef WMC_MAP_VH
`define WMC_MAP_VH
// ---------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------
`define WMC_IDX_PTR0 10'h082
`define WMC_IDX_PTR1 10'h084
`define WMC_IDX_SERIAL_PERIPH_DATA_REG 10'h086
`define WMC_IDX_POWER_CONTROL_REG 10'h087
`define WMC_IDX_WATCHDOG_MEMORY_CONTROL 10'h096
`define WMC_IDX_IE 10'h0A8
`define WMC_IDX_SERIAL_PERIPH_STATUS_REG 10'h0AA
`define WMC_IDX_IP 10'h0B8
`define WMC_IDX_SERIAL_PERIPH_CONTROL_REG 10'h0D5
`define WMC_IDX_IRQ_STAT 10'h0F8
`define WMC_IDX_IRQ_MASK 10'h0F9
// ---------------------------------------------
// Control register fields
// ---------------------------------------------
`define WMC_PS_HI 7
`define WMC_PS_LO 5
`define WMC_EE_WR_EN 4
`define WMC_EE_ACC_EN 3
`define WMC_PTR_SEL 2
`define WMC_KICK 1
`define WMC_WDT_EN 0
`define WMC_POF_BIT 4
`define WMC_SPIF_BIT 7
`define WMC_WRITE_COLLISION_FLAG_BIT 6
`define WMC_SPIE_BIT 7
`define WMC_IRQ_WDT 0
`define WMC_IRQ_EE_DONE 1
`define WMC_IRQ_WRITE_COLLISION_FLAG 2
// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define WMC_RST_WATCHDOG_MEMORY_CONTROL 8'h02
`define WMC_RST_SERIAL_PERIPH_CONTROL_REG 8'h04
`define WMC_RST_BYTE 8'h00
`define WMC_RST_PTR 16'h0000
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define WMC_PCLK_KHZ 20000
`define WMC_WDT_MIN_MS 16
`define WMC_WDT_MAX_MS 2048
`define WMC_EE_PROG_CYCLES 200
`endif

// File: hdl/wmc_regs.v
`timescale 1ns/1ns
`include "wmc_map.vh"
module wmc_regs #(
  parameter WDT_BASE_CYCLES = `WMC_WDT_MIN_MS * `WMC_PCLK_KHZ,
  parameter EE_PROG_CYCLES = `WMC_EE_PROG_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire por_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire xmove_req,
  input wire xmove_write,
  input wire spi_busy,
  input wire spi_done,
  input wire spi_rx_valid,
  input wire [7:0] spi_rx_data,
  output reg [15:0] data_pointer,
  output reg eeprom_route,
  output reg ext_move_start,
  output reg ee_write_start,
  output reg spi_load,
  output reg [7:0] spi_tx_data,
  output reg spi_int_req,
  output reg [5:0] interrupt_priority,
  output reg wdt_reset,
  output reg irq
);

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  reg [7:0] watchdog_memory_control_reg;
  reg kick_reg;
  reg [15:0] ptr0_reg;
  reg [15:0] ptr1_reg;
  reg [7:0] serial_periph_data_reg_reg;
  reg spif_reg;
  reg write_collision_flag_reg;
  reg clr_armed_reg;
  reg [7:0] serial_periph_control_reg_reg;
  reg [7:0] ie_reg;
  reg [5:0] ip_reg;
  reg [6:0] power_control_reg_reg;
  reg pof_reg;
  reg ee_busy_reg;
  reg [31:0] ee_cnt_reg;
  reg [31:0] wdt_cnt_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg [31:0] rd_next;
  reg hit_next;

  // ---------------------------------------------
  // Bus decode
  // ---------------------------------------------
  wire [9:0] idx = paddr[11:2];
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wr = access && pwrite && !pslverr;
  wire rd = access && !pwrite && !pslverr;
  wire [7:0] wb = pwdata[7:0];
  wire ready_flag = !ee_busy_reg;
  wire [2:0] ps = watchdog_memory_control_reg[`WMC_PS_HI:`WMC_PS_LO];
  wire [31:0] wdt_limit = WDT_BASE_CYCLES << ps;
  wire wdt_expire = watchdog_memory_control_reg[`WMC_WDT_EN] && !kick_reg &&
                    (wdt_cnt_reg >= wdt_limit - 32'h0000_0001);
  wire serial_periph_data_reg_hit = access && (idx == `WMC_IDX_SERIAL_PERIPH_DATA_REG);
  wire serial_periph_data_reg_wr_ok = wr && (idx == `WMC_IDX_SERIAL_PERIPH_DATA_REG) && !spi_busy;
  wire write_collision_flag_evt = wr && (idx == `WMC_IDX_SERIAL_PERIPH_DATA_REG) && spi_busy;
  wire ee_go = xmove_req && xmove_write && watchdog_memory_control_reg[`WMC_EE_ACC_EN] &&
               watchdog_memory_control_reg[`WMC_EE_WR_EN] && ready_flag;
  wire ee_done = ee_busy_reg && (ee_cnt_reg == 32'h0000_0000);
  wire [2:0] irq_evt;

  assign irq_evt[`WMC_IRQ_WDT] = wdt_expire;
  assign irq_evt[`WMC_IRQ_EE_DONE] = ee_done;
  assign irq_evt[`WMC_IRQ_WRITE_COLLISION_FLAG] = write_collision_flag_evt;

  // Named strobes keep the clocked blocks short
  wire watchdog_memory_control_wr = wr && (idx == `WMC_IDX_WATCHDOG_MEMORY_CONTROL);
  wire power_control_reg_wr = wr && (idx == `WMC_IDX_POWER_CONTROL_REG);
  wire serial_periph_status_reg_rd = rd && (idx == `WMC_IDX_SERIAL_PERIPH_STATUS_REG);
  wire stat_clr = wr && (idx == `WMC_IDX_IRQ_STAT);
  // Expiry also clears, so a missed restart repeats the reset
  wire wdt_clear = !watchdog_memory_control_reg[`WMC_WDT_EN] || kick_reg || wdt_expire;
  wire [2:0] stat_next;

  // ---------------------------------------------
  // Sticky status, one cell per event
  // ---------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_stat
      // Set wins: an event in the clearing cycle is never lost
      assign stat_next[g] = irq_evt[g] | (irq_stat_reg[g] & !(stat_clr && wb[g]));
    end
  endgenerate

  // ---------------------------------------------
  // Read mux
  // ---------------------------------------------

  always @* begin
    rd_next = 32'h0000_0000;
    hit_next = 1'b1;
    case (idx)
      `WMC_IDX_PTR0: rd_next[15:0] = ptr0_reg;
      `WMC_IDX_PTR1: rd_next[15:0] = ptr1_reg;
      `WMC_IDX_SERIAL_PERIPH_DATA_REG: rd_next[7:0] = serial_periph_data_reg_reg;
      `WMC_IDX_POWER_CONTROL_REG: rd_next[7:0] = {power_control_reg_reg[6:4], pof_reg, power_control_reg_reg[3:0]};
      `WMC_IDX_WATCHDOG_MEMORY_CONTROL: rd_next[7:0] = {watchdog_memory_control_reg[7:2], ready_flag, watchdog_memory_control_reg[0]};
      `WMC_IDX_IE: rd_next[7:0] = {ie_reg[7], 1'b0, ie_reg[5:0]};
      `WMC_IDX_SERIAL_PERIPH_STATUS_REG: rd_next[7:0] = {spif_reg, write_collision_flag_reg, 6'b00_0000};
      `WMC_IDX_IP: rd_next[5:0] = ip_reg;
      `WMC_IDX_SERIAL_PERIPH_CONTROL_REG: rd_next[7:0] = serial_periph_control_reg_reg;
      `WMC_IDX_IRQ_STAT: rd_next[2:0] = irq_stat_reg;
      `WMC_IDX_IRQ_MASK: rd_next[2:0] = irq_mask_reg;
      default: hit_next = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      hit_next = 1'b0;
    end
  end

  // ---------------------------------------------
  // Bus answer, one access cycle, no wait
  // ---------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !hit_next;
        prdata <= hit_next ? rd_next : 32'h0000_0000;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Control register, pointers, plain registers
  // ---------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_memory_control_reg <= `WMC_RST_WATCHDOG_MEMORY_CONTROL;
      kick_reg <= 1'b0;
      ptr0_reg <= `WMC_RST_PTR;
      ptr1_reg <= `WMC_RST_PTR;
      serial_periph_control_reg_reg <= `WMC_RST_SERIAL_PERIPH_CONTROL_REG;
      ie_reg <= `WMC_RST_BYTE;
      ip_reg <= 6'b00_0000;
      power_control_reg_reg <= 7'b000_0000;
      irq_mask_reg <= 3'b000;
    end else begin
      kick_reg <= watchdog_memory_control_wr && wb[`WMC_KICK];
      if (wr) begin
        case (idx)
          `WMC_IDX_WATCHDOG_MEMORY_CONTROL: watchdog_memory_control_reg <= {wb[7:2], 1'b0, wb[0]};
          `WMC_IDX_PTR0: ptr0_reg <= pwdata[15:0];
          `WMC_IDX_PTR1: ptr1_reg <= pwdata[15:0];
          `WMC_IDX_SERIAL_PERIPH_CONTROL_REG: serial_periph_control_reg_reg <= wb;
          `WMC_IDX_IE: ie_reg <= {wb[7], 1'b0, wb[5:0]};
          `WMC_IDX_IP: ip_reg <= wb[5:0];
          `WMC_IDX_POWER_CONTROL_REG: power_control_reg_reg <= {wb[7:5], wb[3:0]};
          `WMC_IDX_IRQ_MASK: irq_mask_reg <= wb[2:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------
  // Power-lost flag, power-on sets it, a register write loads it from data bit 4
  // ---------------------------------------------
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pof_reg <= 1'b1;
    end else if (power_control_reg_wr) begin
      pof_reg <= wb[`WMC_POF_BIT];
    end
  end

  // ---------------------------------------------
  // Serial data register, no reset on purpose
  // ---------------------------------------------
  always @(posedge pclk) begin
    if (serial_periph_data_reg_wr_ok) begin
      serial_periph_data_reg_reg <= wb;
    end else if (spi_rx_valid) begin
      serial_periph_data_reg_reg <= spi_rx_data;
    end
  end

  // ---------------------------------------------
  // Transmit hand-over, second buffer stage
  // ---------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_load <= 1'b0;
      spi_tx_data <= `WMC_RST_BYTE;
    end else begin
      spi_load <= serial_periph_data_reg_wr_ok;
      // Held until the next accepted write, so the shifter may load late
      if (serial_periph_data_reg_wr_ok) begin
        spi_tx_data <= wb;
      end
    end
  end

  // ---------------------------------------------
  // Collision and done flags
  // ---------------------------------------------
  // Set wins over the clear sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spif_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      clr_armed_reg <= 1'b0;
    end else begin
      if (serial_periph_status_reg_rd) begin
        clr_armed_reg <= spif_reg && write_collision_flag_reg;
      end else if (serial_periph_data_reg_hit) begin
        clr_armed_reg <= 1'b0;
      end
      if (spi_done) begin
        spif_reg <= 1'b1;
      end else if (serial_periph_data_reg_hit && clr_armed_reg) begin
        spif_reg <= 1'b0;
      end
      if (write_collision_flag_evt) begin
        write_collision_flag_reg <= 1'b1;
      end else if (serial_periph_data_reg_hit && clr_armed_reg) begin
        write_collision_flag_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Data moves and EEPROM programming
  // ---------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pointer <= `WMC_RST_PTR;
      eeprom_route <= 1'b0;
      ext_move_start <= 1'b0;
      ee_write_start <= 1'b0;
      ee_busy_reg <= 1'b0;
      ee_cnt_reg <= 32'h0000_0000;
    end else begin
      data_pointer <= watchdog_memory_control_reg[`WMC_PTR_SEL] ? ptr1_reg : ptr0_reg;
      eeprom_route <= watchdog_memory_control_reg[`WMC_EE_ACC_EN];
      ext_move_start <= xmove_req && !watchdog_memory_control_reg[`WMC_EE_ACC_EN];
      // Write without the enable bit is dropped, protecting the cells
      ee_write_start <= ee_go;
      if (ee_go) begin
        ee_busy_reg <= 1'b1;
        ee_cnt_reg <= EE_PROG_CYCLES - 1;
      end else if (ee_done) begin
        ee_busy_reg <= 1'b0;
      end else if (ee_busy_reg) begin
        ee_cnt_reg <= ee_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------
  // Watchdog
  // ---------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_reg <= 32'h0000_0000;
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= wdt_expire;
      if (wdt_clear) begin
        wdt_cnt_reg <= 32'h0000_0000;
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------
  // Interrupt status, mask and outputs
  // ---------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'b000;
      irq <= 1'b0;
      spi_int_req <= 1'b0;
      interrupt_priority <= 6'b00_0000;
    end else begin
      irq_stat_reg <= stat_next;
      irq <= |(irq_stat_reg & irq_mask_reg);
      spi_int_req <= spif_reg && serial_periph_control_reg_reg[`WMC_SPIE_BIT];
      interrupt_priority <= ip_reg;
    end
  end

endmodule

// File: tb/wmc_regs_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checks for the control register bank
// ----------------------------------------
module wmc_regs_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire xmove_req,
  input wire spi_busy,
  input wire eeprom_route,
  input wire ext_move_start,
  input wire spi_load,
  input wire [7:0] spi_tx_data,
  input wire [5:0] interrupt_priority,
  input wire wdt_reset
);
  wire wr = psel && penable && pready && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_route_copy: assert property (
    wr && paddr == 12'h258 |-> ##2 eeprom_route == $past(pwdata[3], 2))
    else $error("route does not follow access enable");
  a_ext_route: assert property (xmove_req && !eeprom_route |=> ext_move_start)
    else $error("external move not started");
  a_ext_only: assert property (
    ext_move_start |-> $past(xmove_req) && !$past(eeprom_route))
    else $error("external move without cause");
  a_tx_load: assert property (
    wr && paddr == 12'h218 && !spi_busy |=> spi_load && spi_tx_data == $past(pwdata[7:0]))
    else $error("idle data write not loaded");
  a_coll_block: assert property (wr && paddr == 12'h218 && spi_busy |=> !spi_load)
    else $error("busy data write was loaded");
  a_prio_copy: assert property (
    wr && paddr == 12'h2E0 |-> ##2 interrupt_priority == $past(pwdata[5:0], 2))
    else $error("priority copy wrong");
  a_wdt_single: assert property (wdt_reset |=> !wdt_reset)
    else $error("expiry pulse too long");
endmodule

// File: tb/wmc_regs_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Directed bench, short watchdog and EEPROM counts
// ----------------------------------------
module wmc_regs_tb;
  reg pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  reg xmove_req = 0, xmove_write = 0, spi_busy = 0, spi_done = 0, spi_rx_valid = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [7:0] spi_rx_data = 0;
  reg err;
  wire [31:0] prdata;
  wire [15:0] data_pointer;
  wire [7:0] spi_tx_data;
  wire [5:0] interrupt_priority;
  wire pready, pslverr, eeprom_route, ext_move_start, ee_write_start;
  wire spi_load, spi_int_req, wdt_reset, irq;
  integer num_errors = 0, n_checks = 0, cyc = 0, last = 0, per = 0;
  integer n_wdt = 0, n_ee = 0, n_ext = 0, n_ld = 0, a0, p0, p1, p7;
  wmc_regs #(.WDT_BASE_CYCLES(8), .EE_PROG_CYCLES(4)) u_wmc_regs (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xmove_req(xmove_req), .xmove_write(xmove_write),
    .spi_busy(spi_busy), .spi_done(spi_done), .spi_rx_valid(spi_rx_valid),
    .spi_rx_data(spi_rx_data), .data_pointer(data_pointer), .eeprom_route(eeprom_route),
    .ext_move_start(ext_move_start), .ee_write_start(ee_write_start),
    .spi_load(spi_load), .spi_tx_data(spi_tx_data), .spi_int_req(spi_int_req),
    .interrupt_priority(interrupt_priority), .wdt_reset(wdt_reset), .irq(irq)
  );
  always #25 pclk = ~pclk;
  // Pulses counted mid-cycle, where settled, so none is missed or late
  always @(negedge pclk) begin
    cyc <= cyc + 1;
    if (wdt_reset === 1'b1) begin
      per <= cyc - last;
      last <= cyc;
      n_wdt <= n_wdt + 1;
    end
    if (ee_write_start === 1'b1) n_ee <= n_ee + 1;
    if (ext_move_start === 1'b1) n_ext <= n_ext + 1;
    if (spi_load === 1'b1) n_ld <= n_ld + 1;
  end
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cy(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task xf(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do begin
        @(posedge pclk);
        i = i + 1;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
        num_errors = num_errors + 1;
        finish_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rst;
    begin
      @(posedge pclk);
      presetn <= 0;
      cy(2);
      presetn <= 1;
    end
  endtask
  task xmv;
    begin
      @(posedge pclk);
      xmove_req <= 1;
      xmove_write <= 1;
      @(posedge pclk);
      xmove_req <= 0;
      xmove_write <= 0;
    end
  endtask
  task per_of(input [2:0] ps, output integer p);
    integer i;
    begin
      xf(1, 12'h258, {24'h0, ps, 5'h01});
      a0 = n_wdt;
      i = 0;
      while (n_wdt < a0 + 2 && i < 3000) begin
        @(posedge pclk);
        i = i + 1;
      end
      if (i >= 3000) begin
        num_errors = num_errors + 1;
        finish_test;
      end
      p = per;
    end
  endtask
  task t_reset;
    begin
      xf(0, 12'h258, 0); chk(rd, 32'h0000_0002);
      xf(0, 12'h3FC, 0); chk(err, 1); chk(rd, 0);
      xf(1, 12'h259, 32'h0000_00FF); chk(err, 1);
      xf(0, 12'h21C, 0); chk(rd[4], 1);
      xf(1, 12'h21C, 0);
      rst;
      xf(0, 12'h21C, 0); chk(rd[4], 0);
    end
  endtask
  task t_ptr;
    begin
      xf(1, 12'h208, 32'h0000_1234);
      xf(1, 12'h210, 32'h0000_ABCD);
      xf(1, 12'h258, 32'h0000_0004); cy(2); chk(data_pointer, 16'hABCD);
      xf(1, 12'h258, 0); cy(2); chk(data_pointer, 16'h1234);
      xf(0, 12'h210, 0); chk(rd, 32'h0000_ABCD);
    end
  endtask
  task t_move;
    begin
      a0 = n_ext; xmv; cy(2); chk(n_ext, a0 + 1);
      xf(1, 12'h3E4, 32'h0000_0002);
      xf(1, 12'h258, 32'h0000_0018);
      a0 = n_ext; p0 = n_ee; xmv;
      xf(0, 12'h258, 0); chk(rd[1], 0);
      chk(n_ee, p0 + 1); chk(n_ext, a0);
      cy(8); xf(0, 12'h258, 0); chk(rd[1], 1);
      cy(1); chk(irq, 1);
      xf(1, 12'h3E4, 0); cy(2); chk(irq, 0);
      xf(1, 12'h3E4, 32'h0000_0002); cy(2); chk(irq, 1);
      xf(1, 12'h3E0, 32'h0000_0002); cy(2); chk(irq, 0);
    end
  endtask
  task t_wdt;
    begin
      per_of(0, p0); per_of(1, p1); per_of(7, p7);
      chk(p1 - p0, 8);
      chk(p7 - p0, 1016);
      // Kick first so a long leftover count cannot expire mid-test
      xf(1, 12'h258, 32'h0000_0003); cy(1); a0 = n_wdt;
      repeat (10) xf(1, 12'h258, 32'h0000_0003);
      chk(n_wdt, a0);
      xf(0, 12'h258, 0); chk(rd[1], 1);
      a0 = n_wdt; cy(30); chk(n_wdt > a0, 1);
      xf(1, 12'h258, 0); cy(2); a0 = n_wdt; cy(40); chk(n_wdt, a0);
    end
  endtask
  task t_spi;
    begin
      @(posedge pclk); spi_busy <= 1;
      a0 = n_ld; xf(1, 12'h218, 32'h0000_00A5); cy(2); chk(n_ld, a0);
      xf(0, 12'h2A8, 0); chk(rd[6], 1);
      spi_busy <= 0;
      xf(1, 12'h218, 32'h0000_005A); cy(2); chk(n_ld, a0 + 1);
      chk(spi_tx_data, 8'h5A);
      xf(1, 12'h2E0, 32'h0000_002A); cy(2); chk(interrupt_priority, 6'h2A);
      xf(1, 12'h354, 32'h0000_0084);
      @(posedge pclk); spi_done <= 1;
      @(posedge pclk); spi_done <= 0;
      cy(2); chk(spi_int_req, 1);
      // Clear sequence: status read with both flags set, then a data access
      xf(0, 12'h2A8, 0); chk(rd[7:6], 2'b11);
      xf(0, 12'h218, 0);
      xf(0, 12'h2A8, 0); chk(rd[7:6], 2'b00);
      @(posedge pclk); spi_rx_valid <= 1; spi_rx_data <= 8'h3C;
      @(posedge pclk); spi_rx_valid <= 0;
      rst;
      xf(0, 12'h218, 0); chk(rd, 32'h0000_003C);
    end
  endtask
  initial begin
    cy(16);
    por_n <= 1;
    presetn <= 1;
    t_reset;
    t_ptr;
    t_move;
    t_wdt;
    t_spi;
    finish_test;
  end
endmodule
bind wmc_regs wmc_regs_chk u_wmc_regs_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .xmove_req(xmove_req), .spi_busy(spi_busy), .eeprom_route(eeprom_route),
  .ext_move_start(ext_move_start), .spi_load(spi_load), .spi_tx_data(spi_tx_data),
  .interrupt_priority(interrupt_priority), .wdt_reset(wdt_reset)
);
